// >>> rtl/pwm_preload_map.vh
// Register map, field positions and reset values of the PWM preload control block
`ifndef PWM_PRELOAD_MAP_VH
`define PWM_PRELOAD_MAP_VH
`define OFS_PWMC   8'h00
`define OFS_REP    8'h04
`define OFS_CWH    8'h08
`define OFS_CWL    8'h0c
`define OFS_CVH    8'h10
`define OFS_CVL    8'h14
`define OFS_CUH    8'h18
`define OFS_CUL    8'h1c
`define OFS_C0H    8'h20
`define OFS_C0L    8'h24
`define OFS_CTLA   8'h28
`define OFS_PHS    8'h2c
`define OFS_CTLB   8'h30
`define OFS_POL    8'h34
`define OFS_DTG    8'h38
`define OFS_STAT   8'h3c
`define OFS_ICLR   8'h40
`define OFS_IEN    8'h44
`define LAYOUT_BIT 7
`define FULL_HI    6
`define FULL_LO    4
`define ALIGN_BIT  3
`define PRESC_HI   2
`define PRESC_LO   0
`define CKEN_BIT   0
`define DIRECT_BIT 1
`define EXT_BIT    7
`define CMP_LSB    3
`define IRQ_UPD    0
`define IRQ_COM    1
`define IRQ_W      2
`define WO_MASK    8'h3f
`define LOW_MASK   8'hf8
`define C0H_MASK   8'h0f
`define MASK_FULL  8'hff
`define RST_ZERO   8'h00
`define RST_C0H    8'h0f
`define RST_C0L    8'hff
`define RST_POL    8'h3f
`define RST_DTG    8'hff
`endif

// >>> rtl/pwm_preload_ctrl.v
// PWM control, prescaler, repetition counter, compare preload and write-once locking
`timescale 1ns/1ns
`include "pwm_preload_map.vh"
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module cmp_slot #(
  parameter [7:0] HI_RST  = `RST_ZERO,
  parameter [7:0] LO_RST  = `RST_ZERO,
  parameter [7:0] HI_MASK = `MASK_FULL,
  parameter [7:0] LO_MASK = `MASK_FULL
) (
  input  wire       clock_i,   // Peripheral clock
  input  wire       rstn_i,    // Async reset, active low
  input  wire       wr_hi_i,   // High byte write strobe
  input  wire       wr_lo_i,   // Low byte write strobe
  input  wire [7:0] wdata_i,   // Write byte
  input  wire       update_i,  // Update event pulse
  output reg  [7:0] act_hi_o,  // Active high byte
  output reg  [7:0] act_lo_o   // Active low byte
);
  reg  [7:0] pre_hi_q;
  reg  [7:0] pre_lo_q;
  reg        hi_seen_q;
  reg        lo_seen_q;
  wire       xfer;

  assign xfer = update_i & hi_seen_q & lo_seen_q;

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_hi_q  <= HI_RST;
      pre_lo_q  <= LO_RST;
      act_hi_o  <= HI_RST;
      act_lo_o  <= LO_RST;
      hi_seen_q <= 1'b0;
      lo_seen_q <= 1'b0;
    end else begin
      if (wr_hi_i) begin
        pre_hi_q <= wdata_i & HI_MASK;
      end
      if (wr_lo_i) begin
        pre_lo_q <= wdata_i & LO_MASK;
      end
      // A byte written in the transfer cycle stays armed for the next update
      hi_seen_q <= wr_hi_i | (hi_seen_q & ~xfer);
      lo_seen_q <= wr_lo_i | (lo_seen_q & ~xfer);
      if (xfer) begin
        act_hi_o <= pre_hi_q;
        act_lo_o <= pre_lo_q;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module pwm_preload_ctrl (
  input  wire        clock_i,         // Peripheral clock, 10 MHz
  input  wire        rstn_i,          // Async reset, active low
  input  wire [7:0]  paddr_i,         // APB address
  input  wire        psel_i,          // APB select
  input  wire        penable_i,       // APB enable
  input  wire        pwrite_i,        // APB direction
  input  wire [31:0] pwdata_i,        // APB write data
  output wire [31:0] prdata_o,        // APB read data
  output wire        pready_o,        // APB ready
  output wire        pslverr_o,       // APB error, unmapped address
  input  wire        period_tick_i,   // Counter period (or half period) end
  input  wire        commutation_i,   // Commutation event pulse
  output wire        prescale_tick_o, // PWM counter clock enable
  output wire        center_align_o,  // Counter alignment select
  output wire        update_event_o,  // Update event pulse
  output wire        irq_o,           // Interrupt request level
  output wire [12:0] duty_u_o,        // Active phase U compare
  output wire [12:0] duty_v_o,        // Active phase V compare
  output wire [12:0] duty_w_o,        // Active phase W compare
  output wire [2:0]  extension_o,     // Extension bits U,V,W
  output wire [2:0]  full_duty_o,     // Active full-duty U,V,W
  output wire [11:0] period_cmp_o,    // Active compare 0
  output wire        clock_enable_o,  // Peripheral clock enable
  output wire        direct_access_o, // Direct access mode
  output wire [7:0]  phase_state_o,   // Active phase state
  output wire [7:0]  control_b_o,     // Active control B
  output wire [7:0]  polarity_o,      // Polarity register
  output wire [7:0]  dead_time_o      // Dead time register
);
  reg  [7:0]  pwmc_q;
  reg  [2:0]  full_act_q;
  reg  [7:0]  rep_pre_q;
  reg  [7:0]  rep_act_q;
  reg  [7:0]  rep_cnt_q;
  reg  [1:0]  ctla_q;
  reg         first_q;
  reg  [7:0]  phs_pre_q;
  reg  [7:0]  phs_act_q;
  reg  [7:0]  ctlb_pre_q;
  reg  [7:0]  ctlb_act_q;
  reg  [7:0]  pol_q;
  reg         pol_lock_q;
  reg  [7:0]  dtg_q;
  reg         dtg_lock_q;
  reg  [`IRQ_W-1:0] stat_q;
  reg  [`IRQ_W-1:0] ien_q;
  reg  [`IRQ_W-1:0] stat_set;
  reg  [2:0]  div_q;
  reg  [7:0]  prdata_q;
  reg  [7:0]  rdata_d;
  reg         mapped;
  wire        setup;
  wire        access;
  wire        wr;
  wire [7:0]  wb;
  wire        cken;
  wire        direct;
  wire        upd;
  wire        first_en;
  wire        com_load;
  wire        eight_bit;
  wire [7:0]  uh;
  wire [7:0]  ul;
  wire [7:0]  vh;
  wire [7:0]  vl;
  wire [7:0]  wh;
  wire [7:0]  wl;
  wire [7:0]  c0h;
  wire [7:0]  c0l;

  assign setup  = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign wr     = access & pwrite_i;
  assign wb     = pwdata_i[7:0];
  assign cken   = ctla_q[`CKEN_BIT];
  assign direct = ctla_q[`DIRECT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: code N gives one tick every N+1 clocks
  assign prescale_tick_o = cken & (div_q == pwmc_q[`PRESC_HI:`PRESC_LO]);

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= 3'h0;
    end else if (!cken || prescale_tick_o) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Repetition counter and update event
  assign upd      = cken & period_tick_i & (rep_cnt_q == 8'h00);
  assign first_en = wr & (paddr_i == `OFS_CTLA) & wb[`CKEN_BIT] & ~first_q;
  assign update_event_o = upd;

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rep_pre_q <= `RST_ZERO;
      rep_act_q <= `RST_ZERO;
      rep_cnt_q <= `RST_ZERO;
      first_q   <= 1'b0;
    end else begin
      if (wr && paddr_i == `OFS_REP) begin
        rep_pre_q <= wb;
      end
      if (first_en) begin
        first_q   <= 1'b1;
        rep_act_q <= rep_pre_q;
        rep_cnt_q <= rep_pre_q;
      end else if (upd) begin
        rep_act_q <= rep_pre_q;
        rep_cnt_q <= rep_pre_q;
      end else if (cken && period_tick_i) begin
        rep_cnt_q <= rep_cnt_q - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM control and full-duty bits
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwmc_q     <= `RST_ZERO;
      full_act_q <= 3'h0;
    end else begin
      if (upd) begin
        full_act_q <= pwmc_q[`FULL_HI:`FULL_LO];
      end
      if (wr && paddr_i == `OFS_PWMC) begin
        pwmc_q <= wb; // A write in the update cycle wins over self-clear
      end else if (upd) begin
        pwmc_q[`FULL_HI:`FULL_LO] <= 3'h0;
      end
    end
  end

  assign center_align_o = pwmc_q[`ALIGN_BIT];
  assign eight_bit      = pwmc_q[`LAYOUT_BIT];
  assign full_duty_o    = full_act_q;

  ////////////////////////////////////////////////////////////////////////////
  // Compare preload slots
  cmp_slot #(
    .HI_RST  (`RST_ZERO),
    .LO_RST  (`RST_ZERO),
    .HI_MASK (`MASK_FULL),
    .LO_MASK (`LOW_MASK)
  ) u_slot (
    .clock_i  (clock_i),
    .rstn_i   (rstn_i),
    .wr_hi_i  (wr & (paddr_i == `OFS_CUH)),
    .wr_lo_i  (wr & (paddr_i == `OFS_CUL)),
    .wdata_i  (wb),
    .update_i (upd),
    .act_hi_o (uh),
    .act_lo_o (ul)
  );

  cmp_slot #(
    .HI_RST  (`RST_ZERO),
    .LO_RST  (`RST_ZERO),
    .HI_MASK (`MASK_FULL),
    .LO_MASK (`LOW_MASK)
  ) v_slot (
    .clock_i  (clock_i),
    .rstn_i   (rstn_i),
    .wr_hi_i  (wr & (paddr_i == `OFS_CVH)),
    .wr_lo_i  (wr & (paddr_i == `OFS_CVL)),
    .wdata_i  (wb),
    .update_i (upd),
    .act_hi_o (vh),
    .act_lo_o (vl)
  );

  cmp_slot #(
    .HI_RST  (`RST_ZERO),
    .LO_RST  (`RST_ZERO),
    .HI_MASK (`MASK_FULL),
    .LO_MASK (`LOW_MASK)
  ) w_slot (
    .clock_i  (clock_i),
    .rstn_i   (rstn_i),
    .wr_hi_i  (wr & (paddr_i == `OFS_CWH)),
    .wr_lo_i  (wr & (paddr_i == `OFS_CWL)),
    .wdata_i  (wb),
    .update_i (upd),
    .act_hi_o (wh),
    .act_lo_o (wl)
  );

  cmp_slot #(
    .HI_RST  (`RST_C0H),
    .LO_RST  (`RST_C0L),
    .HI_MASK (`C0H_MASK),
    .LO_MASK (`MASK_FULL)
  ) p_slot (
    .clock_i  (clock_i),
    .rstn_i   (rstn_i),
    .wr_hi_i  (wr & (paddr_i == `OFS_C0H)),
    .wr_lo_i  (wr & (paddr_i == `OFS_C0L)),
    .wdata_i  (wb),
    .update_i (upd),
    .act_hi_o (c0h),
    .act_lo_o (c0l)
  );

  // In 8-bit layout the low byte no longer counts
  assign duty_u_o = eight_bit ? {uh, 5'h00} : {uh, ul[7:`CMP_LSB]};
  assign duty_v_o = eight_bit ? {vh, 5'h00} : {vh, vl[7:`CMP_LSB]};
  assign duty_w_o = eight_bit ? {wh, 5'h00} : {wh, wl[7:`CMP_LSB]};
  assign extension_o = eight_bit ? full_act_q
                                 : {uh[`EXT_BIT], vh[`EXT_BIT], wh[`EXT_BIT]};
  assign period_cmp_o = {c0h[3:0], c0l};

  ////////////////////////////////////////////////////////////////////////////
  // Commutation preloads and control A
  assign com_load = direct ? (wr & (paddr_i == `OFS_PHS)) : commutation_i;

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctla_q     <= 2'h0;
      phs_pre_q  <= `RST_ZERO;
      phs_act_q  <= `RST_ZERO;
      ctlb_pre_q <= `RST_ZERO;
      ctlb_act_q <= `RST_ZERO;
    end else begin
      if (wr && paddr_i == `OFS_CTLA) begin
        ctla_q <= wb[1:0];
      end
      if (wr && paddr_i == `OFS_PHS) begin
        phs_pre_q <= wb;
      end
      if (wr && paddr_i == `OFS_CTLB) begin
        ctlb_pre_q <= wb;
      end
      if (com_load) begin
        // In direct mode the written phase state goes straight through
        phs_act_q  <= direct ? wb : phs_pre_q;
        ctlb_act_q <= ctlb_pre_q;
      end
    end
  end

  assign clock_enable_o  = cken;
  assign direct_access_o = direct;
  assign phase_state_o   = phs_act_q;
  assign control_b_o     = ctlb_act_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write-once bits: the first access of either kind closes them
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pol_q      <= `RST_POL;
      pol_lock_q <= 1'b0;
      dtg_q      <= `RST_DTG;
      dtg_lock_q <= 1'b0;
    end else begin
      if (access && paddr_i == `OFS_POL) begin
        pol_lock_q <= 1'b1;
        if (pwrite_i) begin
          pol_q <= (wb & ~`WO_MASK) | ((pol_lock_q ? pol_q : wb) & `WO_MASK);
        end
      end
      if (access && paddr_i == `OFS_DTG) begin
        dtg_lock_q <= 1'b1;
        if (pwrite_i) begin
          dtg_q <= (wb & ~`WO_MASK) | ((dtg_lock_q ? dtg_q : wb) & `WO_MASK);
        end
      end
    end
  end

  assign polarity_o  = pol_q;
  assign dead_time_o = dtg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear
  always @* begin
    stat_set           = {`IRQ_W{1'b0}};
    stat_set[`IRQ_UPD] = upd | first_en;
    stat_set[`IRQ_COM] = com_load;
  end

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_q <= {`IRQ_W{1'b0}};
      ien_q  <= {`IRQ_W{1'b0}};
    end else begin
      if (wr && paddr_i == `OFS_IEN) begin
        ien_q <= wb[`IRQ_W-1:0];
      end
      if (wr && paddr_i == `OFS_ICLR) begin
        stat_q <= (stat_q & ~wb[`IRQ_W-1:0]) | stat_set;
      end else begin
        stat_q <= stat_q | stat_set;
      end
    end
  end

  assign irq_o = |(stat_q & ien_q);

  ////////////////////////////////////////////////////////////////////////////
  // APB read path, captured in the setup cycle
  always @* begin
    rdata_d = `RST_ZERO;
    mapped  = 1'b1;
    case (paddr_i)
      `OFS_PWMC: rdata_d = pwmc_q;
      `OFS_REP:  rdata_d = rep_act_q;
      `OFS_CWH:  rdata_d = wh;
      `OFS_CWL:  rdata_d = wl;
      `OFS_CVH:  rdata_d = vh;
      `OFS_CVL:  rdata_d = vl;
      `OFS_CUH:  rdata_d = uh;
      `OFS_CUL:  rdata_d = ul;
      `OFS_C0H:  rdata_d = c0h;
      `OFS_C0L:  rdata_d = c0l;
      `OFS_CTLA: rdata_d = {6'h00, ctla_q};
      `OFS_PHS:  rdata_d = phs_act_q;
      `OFS_CTLB: rdata_d = ctlb_act_q;
      `OFS_POL:  rdata_d = pol_q;
      `OFS_DTG:  rdata_d = dtg_q;
      `OFS_STAT: rdata_d = {6'h00, stat_q};
      `OFS_ICLR: rdata_d = `RST_ZERO;
      `OFS_IEN:  rdata_d = {6'h00, ien_q};
      default:   mapped  = 1'b0;
    endcase
  end

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_q <= `RST_ZERO;
    end else if (setup && !pwrite_i) begin
      prdata_q <= rdata_d;
    end
  end

  assign prdata_o  = {24'h000000, prdata_q};
  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~mapped;
endmodule

// >>> bench/pwm_preload_ctrl_properties.sv
// Concurrent checks on the ports of the PWM preload control block
`timescale 1ns/1ns
`include "pwm_preload_map.vh"
module pwm_preload_ctrl_properties (
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        prescale_tick_o,
  input wire logic        period_tick_i,
  input wire logic        center_align_o,
  input wire logic        update_event_o,
  input wire logic        irq_o,
  input wire logic [2:0]  full_duty_o,
  input wire logic [11:0] period_cmp_o,
  input wire logic        clock_enable_o,
  input wire logic [7:0]  polarity_o
);
  wire logic wr = psel_i && penable_i && pwrite_i;
  logic [2:0] code_q;
  logic [3:0] gap_q;
  logic       ok_q;
  logic       lock_q;
  logic       en_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the prescale code; a gap is judged only once a tick follows an unchanged code
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_q <= 3'h0;
      gap_q  <= 4'h0;
      ok_q   <= 1'b0;
      lock_q <= 1'b0;
      en_q   <= 1'b0;
    end else begin
      if (wr && paddr_i == `OFS_PWMC) code_q <= pwdata_i[2:0];
      if (wr && paddr_i == `OFS_IEN) en_q <= pwdata_i[0];
      if (psel_i && penable_i && paddr_i == `OFS_POL) lock_q <= 1'b1;
      gap_q <= prescale_tick_o ? 4'h0 : gap_q + 4'h1;
      ok_q  <= !(wr && paddr_i == `OFS_PWMC) && clock_enable_o && (ok_q || prescale_tick_o);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_align_follows: assert property (wr && paddr_i == `OFS_PWMC |=>
    center_align_o == $past(pwdata_i[3])) else $error("alignment not taken from write");
  a_prescale_gap: assert property (prescale_tick_o && ok_q |->
    gap_q == {1'b0, code_q}) else $error("prescale tick spacing wrong");
  a_update_on_tick: assert property (update_event_o |->
    period_tick_i && clock_enable_o) else $error("update without period end");
  a_full_at_update: assert property ($changed(full_duty_o) |->
    $past(update_event_o)) else $error("full duty moved outside update");
  a_cmp_at_update: assert property ($changed(period_cmp_o) |->
    $past(update_event_o)) else $error("compare moved outside update");
  a_lock_holds: assert property (wr && paddr_i == `OFS_POL && lock_q |=>
    polarity_o[5:0] == $past(polarity_o[5:0])) else $error("locked bits rewritten");
  a_irq_on_update: assert property (update_event_o && en_q &&
    !(wr && paddr_i == `OFS_IEN) |=> irq_o) else $error("update raised no interrupt");
  a_irq_masked: assert property (wr && paddr_i == `OFS_IEN &&
    pwdata_i[1:0] == 2'h0 |=> !irq_o) else $error("interrupt while masked");
endmodule
bind pwm_preload_ctrl pwm_preload_ctrl_properties chk_i (.clock_i, .rstn_i, .paddr_i,
  .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prescale_tick_o, .period_tick_i,
  .center_align_o, .update_event_o, .irq_o, .full_duty_o, .period_cmp_o,
  .clock_enable_o, .polarity_o);

// >>> bench/pwm_far_end.sv
// Far-side model: period ends and commutations paced by the prescaled counter clock
`timescale 1ns/1ns
module pwm_far_end #(
  parameter int PERIOD = 4           // Counter clocks per period, kept short
) (
  input  wire logic clock_i,         // Peripheral clock
  input  wire logic rstn_i,          // Async reset, active low
  input  wire logic count_en_i,      // Prescaled counter clock enable
  input  wire logic comm_en_i,       // Let period ends commutate
  output logic      period_tick_o,   // Period end pulse
  output logic      commutation_o    // Commutation pulse
);
  int cnt_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q         <= 0;
      period_tick_o <= 1'b0;
      commutation_o <= 1'b0;
    end else begin
      period_tick_o <= count_en_i && cnt_q == PERIOD - 1;
      commutation_o <= comm_en_i && count_en_i && cnt_q == PERIOD - 1;
      if (count_en_i) cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    end
  end
endmodule

// >>> bench/pwm_preload_ctrl_test.sv
// Self-checking bench of the PWM preload control block
`timescale 1ns/1ns
module pwm_preload_ctrl_test;
  logic clock_i, rstn_i, psel_i, penable_i, pwrite_i, period_tick_i, commutation_i, comm_en;
  logic [7:0] paddr_i, rd, hu, lu, hv, h0, l0, phase_state_o, control_b_o, polarity_o;
  logic [7:0] dead_time_o;
  logic [31:0] pwdata_i, prdata_o;
  logic pready_o, pslverr_o, prescale_tick_o, center_align_o, update_event_o, irq_o, err;
  logic clock_enable_o, direct_access_o;
  logic [12:0] duty_u_o, duty_v_o, duty_w_o;
  logic [2:0] extension_o, full_duty_o;
  logic [11:0] period_cmp_o;
  int n_fail, checked, seed, n1, n2, tk, i, k;
  int gaps[$];
  int rv[10] = '{0, 0, 0, 0, 0, 0, 0, 0, 15, 255};
  pwm_preload_ctrl pwm_preload_ctrl_i (.*);
  pwm_far_end pwm_far_end_i (.clock_i, .rstn_i, .count_en_i(prescale_tick_o),
    .comm_en_i(comm_en), .period_tick_o(period_tick_i), .commutation_o(commutation_i));
  always #50 clock_i = ~clock_i;
  // Spacing of updates counted in period ends, independent of the main sequence
  always @(posedge clock_i) begin
    if (rstn_i && period_tick_i === 1'b1) tk++;
    if (rstn_i && update_event_o === 1'b1) begin
      gaps.push_back(tk);
      tk = 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task tmo;
    n_fail++;
    print_verdict;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clock_i);
      if (pready_o === 1'b1) break;
    end
    if (k == 20) tmo;
    rd = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(negedge clock_i);
  endtask
  task wupd;
    for (k = 0; k < 400; k++) begin
      @(negedge clock_i);
      if (update_event_o === 1'b1) break;
    end
    if (k == 400) tmo;
    @(negedge clock_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 29982;
    clock_i = 0;
    rstn_i = 0;
    {psel_i, penable_i, pwrite_i, comm_en, paddr_i, pwdata_i} = '0;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    for (i = 0; i < 10; i++) begin
      apb(1'b0, 8'(4 * i), 8'h00);
      chk("reset value", rv[i], rd);
    end
    apb(1'b0, 8'h48, 8'h00);
    chk("unmapped error", 1, err);
    // Write-once bits are touched before anything else of those registers
    apb(1'b1, 8'h38, 8'h2a);
    apb(1'b1, 8'h38, 8'h15);
    chk("dead time", 8'h2a, dead_time_o);
    apb(1'b0, 8'h34, 8'h00);
    apb(1'b1, 8'h34, 8'hc0);
    chk("polarity", 8'hff, polarity_o);
    {hu, lu, hv, h0, l0} = 40'({$random(seed), $random(seed)});
    n1 = 1 + {$random(seed)} % 3;
    n2 = n1 + 1 + {$random(seed)} % 2;
    apb(1'b1, 8'h04, 8'(n1));
    apb(1'b1, 8'h44, 8'h01);
    apb(1'b1, 8'h00, 8'h49);
    chk("center align", 1, center_align_o);
    apb(1'b1, 8'h18, hu);
    apb(1'b1, 8'h1c, lu);
    apb(1'b1, 8'h10, hv);
    apb(1'b1, 8'h20, h0);
    apb(1'b1, 8'h24, l0);
    tk = 0;
    gaps = {};
    apb(1'b1, 8'h28, 8'h01);
    chk("enable irq", 1, irq_o);
    chk("clock enable", 1, clock_enable_o);
    chk("no transfer", 0, duty_u_o);
    apb(1'b1, 8'h04, 8'(n2));
    apb(1'b1, 8'h40, 8'h01);
    chk("irq cleared", 0, irq_o);
    wupd;
    chk("duty u", {hu, lu[7:3]}, duty_u_o);
    chk("duty v", 0, duty_v_o);
    chk("duty w", 0, duty_w_o);
    chk("compare 0", {h0[3:0], l0}, period_cmp_o);
    chk("full duty", 3'b100, full_duty_o);
    chk("extension", {hu[7], 2'b00}, extension_o);
    chk("update irq", 1, irq_o);
    apb(1'b1, 8'h18, ~hu);
    apb(1'b0, 8'h18, 8'h00);
    chk("read active", hu, rd);
    apb(1'b1, 8'h00, 8'ha9);
    apb(1'b1, 8'h1c, lu);
    wupd;
    chk("full duty 2", 3'b010, full_duty_o);
    chk("extension 8", 3'b010, extension_o);
    chk("duty 8", {~hu, 5'h00}, duty_u_o);
    wupd;
    chk("full clear", 0, full_duty_o);
    chk("gap 1", n1 + 1, gaps[0]);
    chk("gap 2", n2 + 1, gaps[1]);
    chk("gap 3", n2 + 1, gaps[2]);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, 8'h00, 8'(i));
      for (k = 0; k < 20 && prescale_tick_o !== 1'b1; k++) @(negedge clock_i);
      if (k == 20) tmo;
      for (k = 1; k < 20; k++) begin
        @(negedge clock_i);
        if (prescale_tick_o === 1'b1) break;
      end
      chk("prescale", i + 1, k);
    end
    chk("edge align", 0, center_align_o);
    apb(1'b1, 8'h2c, 8'h5a);
    apb(1'b1, 8'h30, 8'h33);
    chk("state held", 0, phase_state_o);
    @(posedge clock_i) comm_en <= 1'b1;
    for (k = 0; k < 200 && commutation_i !== 1'b1; k++) @(negedge clock_i);
    if (k == 200) tmo;
    @(posedge clock_i) comm_en <= 1'b0;
    @(negedge clock_i);
    chk("state loaded", 8'h5a, phase_state_o);
    chk("control b", 8'h33, control_b_o);
    apb(1'b1, 8'h28, 8'h03);
    apb(1'b1, 8'h30, 8'hc3);
    apb(1'b1, 8'h2c, 8'ha5);
    chk("direct mode", 1, direct_access_o);
    chk("direct state", 8'ha5, phase_state_o);
    chk("direct ctl b", 8'hc3, control_b_o);
    apb(1'b1, 8'h44, 8'h00);
    chk("masked", 0, irq_o);
    // Only a hardware reset may reopen the write-once bits and rearm the first enable
    @(posedge clock_i) rstn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    apb(1'b1, 8'h38, 8'h15);
    chk("dead time reopened", 8'h15, dead_time_o);
    apb(1'b1, 8'h44, 8'h01);
    apb(1'b1, 8'h28, 8'h01);
    chk("enable irq again", 1, irq_o);
    print_verdict;
  end
endmodule
